// File: verilog/socket_irq_status.v
// socket interrupt routing, general control and status-change flag logic for a 16-bit card slot
// How it works
// - control bit 7 turns the battery/ring pin into a ring indicate input
// - control bit 6 drives card reset: 0 asserts reset, 1 releases
// - control bit 5 records card kind: 0 memory, 1 I/O
// - bit 4 sends change interrupts to PCI, else use select at 05h
// - bits 3..0 route functional irq of an I/O card (bit 5 set): 0 none, 2 SYSTEM_MANAGEMENT_IRQ, else IRQn
// - functional select zero also forces change interrupts to PCI
// - disabled sources read 0; enabled ones set flag and interrupt host
// - flags clear on read or write-one, per global clear-mode bit 2
// - status bits 7..4 always read zero
// - bit 3 sets on any change of either card detect input
// - memory card: bit 2 sets on ready low-to-high edge
// - I/O card: ready change bit held at zero
// - memory card with ring indicate off: bit 1 sets on battery low; I/O card reads 0
// - bit 0 battery dead for memory, status-changed for I/O cards
// - ring indicate enabled: bit 0 reports the ring input instead
// - change line select 0000 means no routing, reset default
`timescale 1ns/10ps
`default_nettype none
`include "socket_irq_consts.vh"
module socket_irq_status (
	input  wire        clk_sys_i,
	input  wire        sys_rst_i,
	input  wire [7:0]  reg_addr_i,
	input  wire [7:0]  reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [7:0]  reg_rdata_o,
	input  wire        flag_clear_by_write_i,
	input  wire        card_detect_first_n_i,
	input  wire        card_detect_second_n_i,
	input  wire        card_ready_i,
	input  wire        battery_ring_pin_i,
	input  wire        battery_second_pin_i,
	input  wire        card_status_changed_n_i,
	input  wire        card_func_irq_i,
	output wire        card_reset_o,
	output wire        change_irq_pci_o,
	output wire [15:0] change_irq_lines_o,
	output wire        change_irq_smi_o,
	output wire [15:0] func_irq_lines_o,
	output wire        func_irq_smi_o,
	output wire        ring_indicate_o
);
	reg  [7:0] ctrl_reg;
	reg  [7:0] cfg_reg;
	reg  [3:0] flags_reg;
	reg  [3:0] flags_next;
	reg        cd1_reg;
	reg        cd2_reg;
	reg        ready_reg;
	reg        batt_reg;
	reg        prev_valid_reg;
	wire       ring_function_enable;
	wire       installed_card_kind;
	wire       change_irq_to_pci;
	wire [3:0] functional_irq_select;
	wire [3:0] change_irq_line_select;
	wire       wr_ctrl;
	wire       wr_cfg;
	wire       wr_status;
	wire       rd_status;
	wire [3:0] set_evt;
	wire [3:0] clr_evt;
	wire [3:0] enables;
	wire       any_flag;
	wire       to_pci;
	wire       battery_low_cond;
	wire       battery_empty_cond;
	wire       bit0_cond;
	wire [3:0] status_view;

	assign ring_function_enable   = ctrl_reg[`CTRL_RING_BIT];
	assign installed_card_kind    = ctrl_reg[`CTRL_CARD_KIND_BIT];
	assign change_irq_to_pci      = ctrl_reg[`CTRL_TO_PCI_BIT];
	assign functional_irq_select  = ctrl_reg[3:0];
	assign change_irq_line_select = cfg_reg[7:4];

	// address decode of register strobes
	assign wr_ctrl   = reg_wr_i && (reg_addr_i == `GEN_CTRL_OFFSET);
	assign wr_cfg    = reg_wr_i && (reg_addr_i == `CHANGE_CFG_OFFSET);
	assign wr_status = reg_wr_i && (reg_addr_i == `STATUS_CHANGE_OFFSET);
	assign rd_status = reg_rd_i && (reg_addr_i == `STATUS_CHANGE_OFFSET);

	// control and configuration registers
	// reset to zero
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ctrl_reg <= `GEN_CTRL_RESET;
			cfg_reg  <= `CHANGE_CFG_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= reg_wdata_i;
			end
			if (wr_cfg) begin
				cfg_reg <= reg_wdata_i;
			end
		end
	end

	assign card_reset_o = ~ctrl_reg[`CTRL_CARD_RESET_BIT];
	assign ring_indicate_o = ring_function_enable && battery_ring_pin_i;

	// battery pin pair decode: 0x dead, 10 low, 11 good
	assign battery_empty_cond = ~battery_ring_pin_i;
	assign battery_low_cond   = battery_ring_pin_i && ~battery_second_pin_i;

	assign bit0_cond = ring_function_enable ? battery_ring_pin_i :
		(installed_card_kind ? ~card_status_changed_n_i : battery_empty_cond);

	// previous-sample registers for edge detection
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			cd1_reg        <= 1'b0;
			cd2_reg        <= 1'b0;
			ready_reg      <= 1'b0;
			batt_reg       <= 1'b0;
			prev_valid_reg <= 1'b0;
		end else begin
			cd1_reg        <= card_detect_first_n_i;
			cd2_reg        <= card_detect_second_n_i;
			ready_reg      <= card_ready_i;
			batt_reg       <= bit0_cond;
			prev_valid_reg <= 1'b1;
		end
	end

	assign enables = cfg_reg[3:0];

	assign set_evt[`FLAG_DETECT_BIT] = prev_valid_reg &&
		((cd1_reg != card_detect_first_n_i) || (cd2_reg != card_detect_second_n_i));
	assign set_evt[`FLAG_READY_BIT] = prev_valid_reg && ~installed_card_kind &&
		~ready_reg && card_ready_i;
	assign set_evt[`FLAG_BATLOW_BIT] = ~installed_card_kind && ~ring_function_enable &&
		battery_low_cond;
	assign set_evt[`FLAG_BATEMPTY_BIT] = bit0_cond;

	assign clr_evt = flag_clear_by_write_i ? (wr_status ? reg_wdata_i[3:0] : 4'h0) :
		(rd_status ? 4'hF : 4'h0);

	// flag update: set wins over clear, disabled sources held at zero
	always @* begin
		flags_next = flags_reg;
		flags_next = (flags_next & ~clr_evt) | set_evt;
		flags_next = flags_next & enables;
		if (installed_card_kind) begin
			flags_next[`FLAG_READY_BIT] = 1'b0;
			flags_next[`FLAG_BATLOW_BIT] = 1'b0;
		end
	end

	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			flags_reg <= 4'h0; // low half of the status reset value
		end else begin
			flags_reg <= flags_next;
		end
	end

	// read data register
	// reserved bits zero
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`GEN_CTRL_OFFSET:      reg_rdata_o <= ctrl_reg;
				`STATUS_CHANGE_OFFSET: reg_rdata_o <= {4'h0, status_view};
				`CHANGE_CFG_OFFSET:    reg_rdata_o <= cfg_reg;
				default:               reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// visible flags, ready and battery-low hidden at once for I/O cards
	assign status_view = flags_reg & enables & (installed_card_kind ? 4'h9 : 4'hF);
	assign any_flag = |status_view;
	assign to_pci = change_irq_to_pci || (functional_irq_select == `IRQ_SEL_NONE);
	assign change_irq_pci_o = any_flag && to_pci;

	irq_line_decode u_change_decode (
		.active_i    (any_flag && ~to_pci),
		.select_i    (change_irq_line_select),
		.irq_lines_o (change_irq_lines_o),
		.smi_o       (change_irq_smi_o)
	);

	irq_line_decode u_func_decode (
		.active_i    (card_func_irq_i && installed_card_kind),
		.select_i    (functional_irq_select),
		.irq_lines_o (func_irq_lines_o),
		.smi_o       (func_irq_smi_o)
	);
endmodule // socket_irq_status
`default_nettype wire

// File: verilog/socket_irq_consts.vh
// register offsets, field positions and codes for the socket interrupt and status-change block
`ifndef SOCKET_IRQ_CONSTS_VH
`define SOCKET_IRQ_CONSTS_VH
`define GEN_CTRL_OFFSET       8'h03
`define STATUS_CHANGE_OFFSET  8'h04
`define CHANGE_CFG_OFFSET     8'h05
`define GEN_CTRL_RESET        8'h00
`define STATUS_CHANGE_RESET   8'h00
`define CHANGE_CFG_RESET      8'h00
`define CTRL_RING_BIT         7
`define CTRL_CARD_RESET_BIT   6
`define CTRL_CARD_KIND_BIT    5
`define CTRL_TO_PCI_BIT       4
`define CFG_DETECT_EN_BIT     3
`define CFG_READY_EN_BIT      2
`define CFG_BATLOW_EN_BIT     1
`define CFG_BATEMPTY_EN_BIT   0
`define FLAG_DETECT_BIT       3
`define FLAG_READY_BIT        2
`define FLAG_BATLOW_BIT       1
`define FLAG_BATEMPTY_BIT     0
`define IRQ_SEL_NONE          4'h0
`define IRQ_SEL_SMI           4'h2
`endif

// File: verilog/irq_line_decode.v
// decodes a 4-bit interrupt select code into one-hot IRQ lines and the SYSTEM_MANAGEMENT_IRQ line
`timescale 1ns/10ps
`default_nettype none
`include "socket_irq_consts.vh"
module irq_line_decode (
	input  wire       active_i,
	input  wire [3:0] select_i,
	output wire [15:0] irq_lines_o,
	output wire       smi_o
);
	// code 0 routes nowhere, code 2 is the management line, others the same-numbered irq
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_line
			if (g == 0 || g == 2) begin : g_none
				assign irq_lines_o[g] = 1'b0;
			end else begin : g_irq
				// code of this line held at the select width
				localparam [3:0] LINE_CODE = g;
				assign irq_lines_o[g] = active_i && (select_i == LINE_CODE);
			end
		end
	endgenerate
	assign smi_o = active_i && (select_i == `IRQ_SEL_SMI);
endmodule // irq_line_decode
`default_nettype wire

// File: verification/socket_irq_status_sva.sv
// assertion checker for the socket interrupt and status-change block
`timescale 1ns/10ps
`default_nettype none
module socket_irq_status_sva (
	input wire logic        clk_sys_i,
	input wire logic        sys_rst_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        card_func_irq_i,
	input wire logic        card_reset_o,
	input wire logic        change_irq_pci_o,
	input wire logic [15:0] change_irq_lines_o,
	input wire logic        change_irq_smi_o,
	input wire logic [15:0] func_irq_lines_o,
	input wire logic        func_irq_smi_o
);
	logic [7:0] ctrl_q;
	// shadow of the control register built from observed writes
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i)
			ctrl_q <= 8'h00;
		else if (reg_wr_i && reg_addr_i == 8'h03)
			ctrl_q <= reg_wdata_i;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	sequence rd_ctrl; reg_rd_i && reg_addr_i == 8'h03 && !reg_wr_i; endsequence
	sequence rd_stat; reg_rd_i && reg_addr_i == 8'h04; endsequence
	// control and status relations
	chk_reset_line: assert property (card_reset_o == !ctrl_q[6])
		else $error("card reset wrong");
	chk_ctrl_read: assert property (rd_ctrl |=> reg_rdata_o == $past(ctrl_q))
		else $error("control readback wrong");
	chk_status_rsvd: assert property (rd_stat |=> reg_rdata_o[7:4] == 4'h0
		&& !($past(ctrl_q[5]) && |reg_rdata_o[2:1])) else $error("status bits wrong");
	chk_func_off: assert property ((ctrl_q[3:0] == 4'h0 || !ctrl_q[5]) [*2] |->
		func_irq_lines_o == 16'h0 && !func_irq_smi_o) else $error("func irq leaks");
	chk_func_smi: assert property ((ctrl_q[5] && ctrl_q[3:0] == 4'h2 && card_func_irq_i)
		[*3] |-> func_irq_smi_o && func_irq_lines_o == 16'h0) else $error("smi route wrong");
	chk_change_pci: assert property ((ctrl_q[4] || ctrl_q[3:0] == 4'h0) [*2] |->
		change_irq_lines_o == 16'h0 && !change_irq_smi_o) else $error("change irq leaks");
	chk_irq_hold: assert property (change_irq_pci_o && !reg_rd_i && !reg_wr_i
		|=> change_irq_pci_o) else $error("irq dropped");
	chk_rst_state: assert property ($fell(sys_rst_i) |-> reg_rdata_o == 8'h00
		&& card_reset_o && !change_irq_pci_o) else $error("reset state wrong");
endmodule // socket_irq_status_sva
`default_nettype wire

// File: verification/socket_card_model.sv
// behavioural card in the socket driving its status pins as commanded
`timescale 1ns/10ps
`default_nettype none
module socket_card_model (
	input  wire logic [6:0] state_i,
	output logic      [6:0] pins_o
);
	// detect, ready, battery, status-changed and irq pins follow the card state
	assign pins_o = state_i;
endmodule // socket_card_model
`default_nettype wire

// File: verification/pccard_socket_interrupt_status_tb.sv
// self-checking bench for the socket interrupt and status-change block
`timescale 1ns/10ps
`default_nettype none
module pccard_socket_interrupt_status_tb;
	logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1, wr_en = 1'b0, rd_en = 1'b0, clr_w = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
	logic [6:0]  card = 7'h38, pins;
	logic [15:0] cl, fl;
	logic        crst, cpci, csmi, fsmi, ri;
	logic [16:0] seed = 17'd78742;
	int          error_cnt = 0, compares = 0, cyc = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	socket_card_model card_u (.state_i(card), .pins_o(pins));
	socket_irq_status dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr_en), .reg_rd_i(rd_en), .reg_rdata_o(rdata),
		.flag_clear_by_write_i(clr_w), .card_detect_first_n_i(pins[0]),
		.card_detect_second_n_i(pins[1]), .card_ready_i(pins[2]), .battery_ring_pin_i(pins[3]),
		.battery_second_pin_i(pins[4]), .card_status_changed_n_i(pins[5]),
		.card_func_irq_i(pins[6]), .card_reset_o(crst), .change_irq_pci_o(cpci),
		.change_irq_lines_o(cl), .change_irq_smi_o(csmi), .func_irq_lines_o(fl),
		.func_irq_smi_o(fsmi), .ring_indicate_o(ri));
	// comparison, bus cycles and reference routing
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(negedge clk_sys_i) {addr, wdata, wr_en} = {a, d, 1'b1};
		@(negedge clk_sys_i) wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(negedge clk_sys_i) {addr, rd_en} = {a, 1'b1};
		@(negedge clk_sys_i) rd_en = 1'b0;
		chk("rdata", {8'h00, rdata}, {8'h00, exp});
	endtask
	task automatic pin(input int b, input logic v);
		@(negedge clk_sys_i) card[b] = v;
		repeat (3) @(negedge clk_sys_i);
	endtask
	function automatic logic [15:0] route(input logic [3:0] s);
		return (s == 4'h0 || s == 4'h2) ? 16'h0 : 16'h1 << s;
	endfunction
	task automatic tally_and_finish;
		if (error_cnt == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// hang guard
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	// main sequence
	initial begin
		repeat (16) @(negedge clk_sys_i);
		sys_rst_i = 1'b0;
		rd(8'h03, 8'h00);
		rd(8'h05, 8'h00);
		for (int i = 0; i < 8; i++) begin
			seed = {seed[15:0], seed[16] ^ seed[13]};
			wr(8'h03, seed[7:0]);
			rd(8'h03, seed[7:0]);
			chk("card_reset", crst, !seed[6]);
		end
		card[6] = 1'b1;
		for (int s = 0; s < 16; s++) begin
			wr(8'h03, 8'h60 | 8'(s));
			repeat (2) @(negedge clk_sys_i);
			chk("func_lines", fl, route(4'(s)));
			chk("func_smi", fsmi, s == 2);
		end
		card[6] = 1'b0;
		wr(8'h03, 8'h41);
		for (int s = 0; s < 16; s++) begin
			wr(8'h05, {4'(s), 4'h8});
			pin(0, !card[0]);
			chk("chg_lines", cl, route(4'(s)));
			chk("chg_smi", csmi, s == 2);
			// the host reads the source after the interrupt
			rd(8'h04, 8'h08);
			chk("chg_cleared", cl, 16'h0);
		end
		wr(8'h05, 8'h38);
		for (int m = 0; m < 2; m++) begin
			wr(8'h03, m ? 8'h40 : 8'h51);
			pin(1, !card[1]);
			chk("chg_pci", cpci, 1'b1);
			rd(8'h04, 8'h08);
		end
		clr_w = 1'b1;
		pin(0, !card[0]);
		rd(8'h04, 8'h08);
		rd(8'h04, 8'h08);
		wr(8'h04, 8'h08);
		rd(8'h04, 8'h00);
		clr_w = 1'b0;
		wr(8'h05, 8'h30);
		pin(0, !card[0]);
		rd(8'h04, 8'h00);
		wr(8'h05, 8'h07);
		pin(2, 1'b1);
		rd(8'h04, 8'h04);
		pin(3, 1'b0);
		pin(3, 1'b1);
		rd(8'h04, 8'h01);
		pin(4, 1'b0);
		pin(4, 1'b1);
		rd(8'h04, 8'h02);
		wr(8'h03, 8'h60);
		pin(2, 1'b0);
		pin(2, 1'b1);
		pin(4, 1'b0);
		pin(4, 1'b1);
		pin(5, 1'b0);
		pin(5, 1'b1);
		rd(8'h04, 8'h01);
		wr(8'h03, 8'hC0);
		chk("ring_out", ri, 1'b1);
		pin(3, 1'b0);
		chk("ring_off", ri, 1'b0);
		rd(8'h04, 8'h01);
		rd(8'h04, 8'h00);
		tally_and_finish();
	end
endmodule // pccard_socket_interrupt_status_tb
bind socket_irq_status socket_irq_status_sva chk_u (.*);
`default_nettype wire
